// file: hw/fss_regs.vh
// Constants for the flash security and suspend command block
// Behaviour
// (R1) Unique ID: 4B, zero address, dummy, 128 bits
// (R2) Three separate 512-byte security registers
// (R3) Security erase 44 needs write enable latch
// (R4) Erase only if select rises after address
// (R5) Erase self-timed; busy until done; latch cleared
// (R6) Locked register ignores erase and program
// (R7) Address: 00, register 1-3, 000b, byte offset
// (R8) Program 42: latch, opcode, address, data bytes
// (R9) Program self-timed; busy until done; latch cleared
// (R10) Read 48: address, dummy, data on falling edges
// (R11) Read address wraps 1FF to 000
// (R12) Host sends 66 then 99 in frames
// (R13) Reset aborts work and clears volatile state
// (R14) Refuse commands during reset recovery
// (R15) Host checks busy and suspend before reset
// (R16) Suspend 75 only during program or erase
// (R17) Suspend flag at once; busy clears within latency
// (R18) Program suspend refuses writes, erases, programs
// (R19) Erase suspend refuses writes and erases
// (R20) Reads elsewhere served while suspended
// (R21) Resume 7A only when suspended and idle
// (R22) Resume clears flag, busy back within 200ns
// (R23) Unique ID shifted MSB first on falling edges
`ifndef FSS_REGS_VH
`define FSS_REGS_VH
`define FSS_OP_WRITE_ENABLE_CMD 8'h06
`define FSS_OP_WRDI 8'h04
`define FSS_OP_WRSR 8'h01
`define FSS_OP_UID 8'h4B
`define FSS_OP_SEC_ERASE 8'h44
`define FSS_OP_SEC_PROG 8'h42
`define FSS_OP_SEC_READ 8'h48
`define FSS_OP_RST_EN 8'h66
`define FSS_OP_RST 8'h99
`define FSS_OP_SUSPEND 8'h75
`define FSS_OP_RESUME 8'h7A
`define FSS_OP_PP 8'h02
`define FSS_OP_QPP 8'h32
`define FSS_OP_SE 8'h20
`define FSS_OP_BE32 8'h52
`define FSS_OP_BE64 8'hD8
`define FSS_OP_CE1 8'hC7
`define FSS_OP_CE2 8'h60
`define FSS_SEC_BYTES 512
`define FSS_SEC_AW 11
`define FSS_UID_BITS 128
`define FSS_CLK_MHZ 100
`define FSS_RESUME_NS 200
`define FSS_RESUME_CYC ((`FSS_RESUME_NS * `FSS_CLK_MHZ) / 1000)
`define FSS_SUSPEND_US 20
`define FSS_SUSPEND_CYC (`FSS_SUSPEND_US * `FSS_CLK_MHZ)
`define FSS_ERASE_US 100
`define FSS_PROG_US 50
`define FSS_RST_US 30
`endif

// file: hw/fss_sync.v
// Three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
module fss_sync (
    input wire clk,
    input wire rst_n,
    input wire rst_val,
    input wire din,
    output reg dout
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    // Reset value fixed at 1 for every stage and dout, whatever rst_val is
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            dout <= 1'b1;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                dout <= s3_reg;
            end
        end
    end
    // rst_val reserved for symmetry; every instance here passes 1
    wire unused_ok = rst_val;
endmodule // fss_sync

// file: hw/fss_timer.v
// Self-timed cycle counter with pause, for erase, program and recovery
`timescale 1ns/1ps
module fss_timer #(
    parameter WIDTH = 24
) (
    input wire clk,
    input wire rst_n,
    input wire clear,
    input wire load,
    input wire [WIDTH-1:0] count,
    input wire run,
    output wire done,
    output wire busy
);
    reg [WIDTH-1:0] cnt_reg;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= {WIDTH{1'b0}};
        end else if (clear) begin
            cnt_reg <= {WIDTH{1'b0}};
        end else if (load) begin
            cnt_reg <= count;
        end else if (run && cnt_reg != {WIDTH{1'b0}}) begin
            cnt_reg <= cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
    assign busy = (cnt_reg != {WIDTH{1'b0}});
    assign done = run && (cnt_reg == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule // fss_timer

// file: hw/fss_ctrl.v
// Serial flash security, reset and suspend command handling
`timescale 1ns/1ps
`include "fss_regs.vh"
module fss_ctrl #(
    parameter ERASE_CYC = `FSS_ERASE_US * `FSS_CLK_MHZ,
    parameter PROG_CYC = `FSS_PROG_US * `FSS_CLK_MHZ,
    parameter RST_CYC = `FSS_RST_US * `FSS_CLK_MHZ,
    parameter SUSPEND_CYC = `FSS_SUSPEND_CYC,
    parameter [127:0] UNIQUE_ID = 128'h0123456789ABCDEF_FEDCBA9876543210
) (
    input wire core_clk,
    input wire rst_n,
    input wire cs_n,
    input wire sclk,
    input wire si,
    output reg so,
    output reg so_oe_n,
    input wire sec_lock_bit_1,
    input wire sec_lock_bit_2,
    input wire sec_lock_bit_3,
    input wire array_op_start,
    input wire array_op_is_erase,
    input wire [23:0] array_op_addr,
    input wire [23:0] read_addr,
    output wire read_allowed,
    output reg write_in_progress,
    output reg write_enable_latch,
    output reg [1:0] suspend_flags,
    output reg reset_busy,
    output reg [7:0] continuous_read_mode_bits,
    output reg [2:0] wrap_setting_bits
);
    // UNIQUE_ID default is arbitrary.
    // ----------------------------------------------------------------
    // Pin sampling
    // ----------------------------------------------------------------
    wire cs_s;
    wire sclk_s;
    wire si_s;
    reg sclk_d_reg;
    reg cs_d_reg;
    fss_sync u_cs (.clk(core_clk), .rst_n(rst_n), .rst_val(1'b1),
        .din(cs_n), .dout(cs_s));
    fss_sync u_sclk (.clk(core_clk), .rst_n(rst_n), .rst_val(1'b1),
        .din(sclk), .dout(sclk_s));
    fss_sync u_si (.clk(core_clk), .rst_n(rst_n), .rst_val(1'b1),
        .din(si), .dout(si_s));
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d_reg <= 1'b1;
            cs_d_reg <= 1'b1;
        end else begin
            sclk_d_reg <= sclk_s;
            cs_d_reg <= cs_s;
        end
    end
    wire rise = !cs_s && sclk_s && !sclk_d_reg;
    wire fall = !cs_s && !sclk_s && sclk_d_reg;
    wire cs_rise = cs_s && !cs_d_reg;
    wire cs_fall = !cs_s && cs_d_reg;

    // ----------------------------------------------------------------
    // Frame shifter
    // ----------------------------------------------------------------
    reg [7:0] op_reg;
    reg [23:0] addr_reg;
    reg [7:0] shift_reg;
    reg [12:0] bitcnt_reg;
    reg [8:0] boff_reg;
    reg data_seen_reg;
    reg [1:0] ocnt_reg;
    reg [6:0] uid_idx_reg;
    reg [7:0] out_reg;
    reg rst_armed_reg;
    // Security storage: flip-flops indexed by register and byte offset
    reg [7:0] sec_mem [0:3*`FSS_SEC_BYTES-1]; // (R2)
    reg [7:0] pbuf [0:`FSS_SEC_BYTES-1];
    reg [`FSS_SEC_BYTES-1:0] pvalid_reg;
    wire [7:0] shift_next = {shift_reg[6:0], si_s};
    wire [1:0] sel = addr_reg[13:12];
    // (R7)
    wire addr_ok = addr_reg[23:16] == 8'h00 && addr_reg[15:14] == 2'b00
        && sel != 2'b00 && addr_reg[11:9] == 3'b000;
    wire locked = (sel == 2'b01 && sec_lock_bit_1)
        || (sel == 2'b10 && sec_lock_bit_2)
        || (sel == 2'b11 && sec_lock_bit_3); // (R6)
    wire [10:0] mem_idx = {sel - 2'b01, boff_reg};
    wire byte_done = rise && bitcnt_reg[2:0] == 3'b111;
    wire [12:0] bitnum = bitcnt_reg + 13'h0001;
    wire prog_sus = suspend_flags[0];
    wire erase_sus = suspend_flags[1];
    // (R18) (R19)
    wire refuse_write = prog_sus || erase_sus;
    wire refuse_prog = prog_sus;

    // ----------------------------------------------------------------
    // Self-timed operation state
    // ----------------------------------------------------------------
    localparam ST_IDLE = 4'b0001;
    localparam ST_SEC = 4'b0010;
    localparam ST_ARRAY = 4'b0100;
    localparam ST_RST = 4'b1000;
    reg [3:0] state_reg;
    reg is_erase_reg;
    reg [1:0] tgt_reg;
    reg [23:0] op_addr_reg;
    reg resume_pend_reg;
    reg [8:0] rcnt_reg;
    localparam [31:0] RESUME_CYC = `FSS_RESUME_CYC;
    reg [23:0] scnt_reg;
    reg t_clear;
    reg t_load;
    reg [23:0] t_count;
    wire t_done;
    wire t_busy;
    wire t_run = write_in_progress || state_reg == ST_RST;
    fss_timer #(.WIDTH(24)) u_tmr (.clk(core_clk), .rst_n(rst_n),
        .clear(t_clear), .load(t_load), .count(t_count), .run(t_run),
        .done(t_done), .busy(t_busy));
    // (R20)
    assign read_allowed = !(suspend_flags != 2'b00 &&
        read_addr[23:12] == op_addr_reg[23:12]);
    wire cmd_ok = state_reg != ST_RST; // (R14)
    integer i;
    always @(posedge core_clk) begin
        if (cs_rise && cmd_ok && state_reg == ST_IDLE && !refuse_write &&
            op_reg == `FSS_OP_SEC_ERASE && bitcnt_reg == 13'd32 &&
            write_enable_latch && addr_ok && !locked) begin
            for (i = 0; i < `FSS_SEC_BYTES; i = i + 1) begin
                sec_mem[{sel - 2'b01, i[8:0]}] <= 8'hFF;
            end
        end
        if (t_done && state_reg == ST_SEC && !is_erase_reg) begin
            for (i = 0; i < `FSS_SEC_BYTES; i = i + 1) begin
                if (pvalid_reg[i]) begin
                    sec_mem[{tgt_reg - 2'b01, i[8:0]}] <=
                        sec_mem[{tgt_reg - 2'b01, i[8:0]}] & pbuf[i];
                end
            end
        end
        // Pending program data is frozen until it is committed
        if (byte_done && op_reg == `FSS_OP_SEC_PROG &&
            bitcnt_reg >= 13'd39 && state_reg != ST_SEC)
            pbuf[boff_reg] <= shift_next;
    end

    // ----------------------------------------------------------------
    // Command decode and output shifting
    // ----------------------------------------------------------------
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_reg <= 8'h00;
            addr_reg <= 24'h000000;
            shift_reg <= 8'h00;
            bitcnt_reg <= 13'h0000;
            boff_reg <= 9'h000;
            data_seen_reg <= 1'b0;
            uid_idx_reg <= 7'h00;
            out_reg <= 8'h00;
            so <= 1'b0;
            so_oe_n <= 1'b1;
            pvalid_reg <= {`FSS_SEC_BYTES{1'b0}};
            ocnt_reg <= 2'b00;
        end else if (cs_s) begin
            bitcnt_reg <= 13'h0000;
            so_oe_n <= 1'b1;
        end else begin
            if (cs_fall) begin
                data_seen_reg <= 1'b0;
                if (state_reg != ST_SEC)
                    pvalid_reg <= {`FSS_SEC_BYTES{1'b0}};
            end
            if (rise) begin
                shift_reg <= shift_next;
                if (bitcnt_reg != 13'h1FFF)
                    bitcnt_reg <= bitnum;
                if (bitcnt_reg == 13'd7)
                    op_reg <= shift_next;
                if (bitcnt_reg >= 13'd8 && bitcnt_reg < 13'd32)
                    addr_reg <= {addr_reg[22:0], si_s};
                if (bitcnt_reg == 13'd31)
                    boff_reg <= {addr_reg[7:0], si_s};
                if (byte_done && op_reg == `FSS_OP_SEC_PROG &&
                    bitcnt_reg >= 13'd39) begin
                    if (state_reg != ST_SEC)
                        pvalid_reg[boff_reg] <= 1'b1;
                    data_seen_reg <= 1'b1;
                    boff_reg <= boff_reg + 9'h001;
                end
                // Load the first output byte once the dummy byte is in
                if (bitcnt_reg == 13'd39) begin
                    uid_idx_reg <= 7'h7F;
                    out_reg <= sec_mem[mem_idx]; // (R10)
                    ocnt_reg <= 2'b01;
                end
            end
            if (fall && cmd_ok && bitcnt_reg >= 13'd40) begin
                if (op_reg == `FSS_OP_UID) begin
                    so_oe_n <= 1'b0;
                    so <= UNIQUE_ID[uid_idx_reg]; // (R1) (R23)
                    uid_idx_reg <= uid_idx_reg - 7'h01;
                end else if (op_reg == `FSS_OP_SEC_READ && addr_ok) begin
                    so_oe_n <= 1'b0;
                    so <= out_reg[7 - bitcnt_reg[2:0]]; // (R10)
                    if (bitcnt_reg[2:0] == 3'b111) begin
                        boff_reg <= boff_reg + 9'h001; // (R11)
                        out_reg <= sec_mem[{sel - 2'b01,
                            boff_reg + 9'h001}];
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Status and self-timed sequencing
    // ----------------------------------------------------------------
    wire end8 = cs_rise && cmd_ok && bitcnt_reg == 13'd8;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            write_in_progress <= 1'b0;
            write_enable_latch <= 1'b0;
            suspend_flags <= 2'b00;
            reset_busy <= 1'b0;
            continuous_read_mode_bits <= 8'h00;
            wrap_setting_bits <= 3'b000;
            is_erase_reg <= 1'b0;
            tgt_reg <= 2'b00;
            op_addr_reg <= 24'h000000;
            rst_armed_reg <= 1'b0;
            resume_pend_reg <= 1'b0;
            rcnt_reg <= 9'h000;
            scnt_reg <= 24'h000000;
            t_clear <= 1'b0;
            t_load <= 1'b0;
            t_count <= 24'h000000;
        end else begin
            t_clear <= 1'b0;
            t_load <= 1'b0;
            if (end8 && op_reg != `FSS_OP_RST)
                rst_armed_reg <= op_reg == `FSS_OP_RST_EN;
            if (end8 && op_reg == `FSS_OP_RST && rst_armed_reg) begin
                state_reg <= ST_RST; // (R13)
                write_in_progress <= 1'b0;
                write_enable_latch <= 1'b0;
                suspend_flags <= 2'b00;
                continuous_read_mode_bits <= 8'h00;
                wrap_setting_bits <= 3'b000;
                resume_pend_reg <= 1'b0;
                scnt_reg <= 24'h000000;
                rst_armed_reg <= 1'b0;
                reset_busy <= 1'b1;
                t_load <= 1'b1;
                t_count <= RST_CYC[23:0];
            end else if (state_reg == ST_RST) begin
                if (t_done) begin
                    state_reg <= ST_IDLE; // (R14)
                    reset_busy <= 1'b0;
                end
            end else begin
                if (end8 && op_reg == `FSS_OP_WRITE_ENABLE_CMD)
                    write_enable_latch <= 1'b1;
                if (end8 && op_reg == `FSS_OP_WRDI)
                    write_enable_latch <= 1'b0;
                if (array_op_start && state_reg == ST_IDLE &&
                    !write_in_progress && write_enable_latch) begin
                    state_reg <= ST_ARRAY;
                    is_erase_reg <= array_op_is_erase;
                    op_addr_reg <= array_op_addr;
                    write_in_progress <= 1'b1;
                    t_load <= 1'b1;
                    t_count <= array_op_is_erase ? ERASE_CYC[23:0]
                        : PROG_CYC[23:0];
                end
                // (R3) (R4) (R5)
                if (cs_rise && state_reg == ST_IDLE && !refuse_write &&
                    op_reg == `FSS_OP_SEC_ERASE && bitcnt_reg == 13'd32 &&
                    write_enable_latch && addr_ok && !locked) begin
                    state_reg <= ST_SEC;
                    is_erase_reg <= 1'b1;
                    tgt_reg <= sel;
                    write_in_progress <= 1'b1;
                    t_load <= 1'b1;
                    t_count <= ERASE_CYC[23:0];
                end
                // (R8) (R9)
                if (cs_rise && state_reg == ST_IDLE && !refuse_prog &&
                    op_reg == `FSS_OP_SEC_PROG && data_seen_reg &&
                    bitcnt_reg[2:0] == 3'b000 &&
                    write_enable_latch && addr_ok && !locked) begin
                    state_reg <= ST_SEC;
                    is_erase_reg <= 1'b0;
                    tgt_reg <= sel;
                    write_in_progress <= 1'b1;
                    t_load <= 1'b1;
                    t_count <= PROG_CYC[23:0];
                end
                if (write_in_progress && t_busy)
                    write_enable_latch <= 1'b0; // (R5) (R9)
                if (t_done && state_reg != ST_IDLE) begin
                    state_reg <= ST_IDLE;
                    write_in_progress <= 1'b0;
                end
                // (R16) (R17)
                if (end8 && op_reg == `FSS_OP_SUSPEND &&
                    state_reg == ST_ARRAY && write_in_progress &&
                    suspend_flags == 2'b00 && !resume_pend_reg) begin
                    suspend_flags <= is_erase_reg ? 2'b10 : 2'b01;
                    scnt_reg <= SUSPEND_CYC[23:0];
                end
                if (scnt_reg != 24'h000000) begin
                    scnt_reg <= scnt_reg - 24'h000001;
                    if (scnt_reg == 24'h000001)
                        write_in_progress <= 1'b0; // (R17)
                end
                // (R21) (R22)
                if (end8 && op_reg == `FSS_OP_RESUME &&
                    suspend_flags != 2'b00 && !write_in_progress &&
                    scnt_reg == 24'h000000) begin
                    suspend_flags <= 2'b00;
                    resume_pend_reg <= 1'b1;
                    rcnt_reg <= RESUME_CYC[8:0];
                end
                if (resume_pend_reg) begin
                    rcnt_reg <= rcnt_reg - 9'h001;
                    if (rcnt_reg <= 9'h001) begin
                        write_in_progress <= 1'b1; // (R22)
                        resume_pend_reg <= 1'b0;
                    end
                end
            end
        end
    end
endmodule // fss_ctrl

// file: test/fss_host_model.sv
// Host-side serial flash controller model that issues command frames
`timescale 1ns/1ps
module fss_host_model (
    input wire core_clk,
    output logic cs_n,
    output logic sclk,
    output logic si,
    input wire so
);
    // ----------------------------------------
    // Mode 0 framing, link clock still between frames
    // ----------------------------------------
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Eight core cycles per half bit gives the 160 ns link period
    task automatic frame(input logic [63:0] tx, input int ntx, input int nrx,
                         output logic [127:0] rx);
        rx = '0;
        cs_n = 1'b0;
        for (int i = 0; i < ntx + nrx; i++) begin
            si = (i < ntx) ? tx[ntx-1-i] : ~si;
            tick(8);
            sclk = 1'b1;
            if (i >= ntx) rx = {rx[126:0], so};
            tick(8);
            sclk = 1'b0;
        end
        tick(8);
        cs_n = 1'b1;
        si = ~si;
        tick(16);
    endtask
endmodule // fss_host_model

// file: test/fss_ctrl_assertions.sv
// Concurrent property checker bound to the security and suspend block
`timescale 1ns/1ps
module fss_ctrl_assertions #(
    parameter int SUSPEND_CYC = 50
) (
    input wire core_clk,
    input wire rst_n,
    input wire cs_n,
    input wire so_oe_n,
    input wire array_op_start,
    input wire [23:0] array_op_addr,
    input wire [23:0] read_addr,
    input wire read_allowed,
    input wire write_in_progress,
    input wire write_enable_latch,
    input wire [1:0] suspend_flags,
    input wire reset_busy,
    input wire [7:0] continuous_read_mode_bits,
    input wire [2:0] wrap_setting_bits
);
    localparam int SUS_MAX = SUSPEND_CYC + 8;
    logic [11:0] sect_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Sector of the last array operation, the one a suspend freezes
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            sect_reg <= 12'h000;
        else if (array_op_start)
            sect_reg <= array_op_addr[23:12];
    end

    oe_idle_a: assert property (cs_n [*8] |-> so_oe_n)
        else $error("output driven while deselected");
    wel_done_a: assert property (
        $fell(write_in_progress) && suspend_flags == 2'b00 && !reset_busy
        ##1 !reset_busy |-> !write_enable_latch)
        else $error("latch still set at completion");
    sus_cause_a: assert property ($rose(|suspend_flags) |->
        $past(write_in_progress))
        else $error("suspend taken while idle");
    sus_latency_a: assert property ($rose(|suspend_flags) |->
        ##[0:SUS_MAX] !write_in_progress)
        else $error("busy not cleared after suspend");
    sus_onehot_a: assert property ($onehot0(suspend_flags))
        else $error("both suspend flags set");
    resume_wip_a: assert property ($fell(|suspend_flags) && !reset_busy
        |-> ##[1:20] write_in_progress)
        else $error("busy late after resume");
    reset_clear_a: assert property ($rose(reset_busy) |-> ##[0:1]
        (!write_enable_latch && suspend_flags == 2'b00 &&
        continuous_read_mode_bits == 8'h00 && wrap_setting_bits == 3'b000))
        else $error("volatile state kept over reset");
    recover_refuse_a: assert property (
        reset_busy && !write_enable_latch ##1 reset_busy |->
        !write_enable_latch)
        else $error("command taken in recovery");
    read_sector_a: assert property (|suspend_flags |->
        read_allowed == (read_addr[23:12] != sect_reg))
        else $error("read permission wrong while suspended");
endmodule // fss_ctrl_assertions

bind fss_ctrl fss_ctrl_assertions #(.SUSPEND_CYC(SUSPEND_CYC)) u_fss_chk (
    .core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .so_oe_n(so_oe_n),
    .array_op_start(array_op_start), .array_op_addr(array_op_addr),
    .read_addr(read_addr), .read_allowed(read_allowed),
    .write_in_progress(write_in_progress),
    .write_enable_latch(write_enable_latch), .suspend_flags(suspend_flags),
    .reset_busy(reset_busy),
    .continuous_read_mode_bits(continuous_read_mode_bits),
    .wrap_setting_bits(wrap_setting_bits)
);

// file: test/fss_ctrl_tb.sv
// Self-checking bench for the flash security and suspend command block
`timescale 1ns/1ps
`include "fss_regs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
$display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module fss_ctrl_tb;
    // Arbitrary identity value
    localparam [127:0] UID = 128'h5A3C96E10F872B4DC3A51E697D08B4F2;
    logic core_clk, rst_n, sec_lock_bit_1, sec_lock_bit_2, sec_lock_bit_3;
    logic array_op_start, array_op_is_erase;
    logic [23:0] array_op_addr, read_addr;
    wire cs_n, sclk, si, so, read_allowed, write_in_progress;
    wire write_enable_latch, reset_busy;
    wire [1:0] suspend_flags;
    logic [127:0] rx;
    logic [31:0] b, r;
    logic [23:0] bad [4] = '{24'h001200, 24'h011000, 24'h000000, 24'h004000};
    integer seed;
    int mismatches, cmp_count;

    fss_ctrl #(.ERASE_CYC(2000), .PROG_CYC(2000), .RST_CYC(400),
        .SUSPEND_CYC(50), .UNIQUE_ID(UID)) u_fss_ctrl (
        .core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
        .si(si), .so(so), .so_oe_n(), .sec_lock_bit_1(sec_lock_bit_1),
        .sec_lock_bit_2(sec_lock_bit_2), .sec_lock_bit_3(sec_lock_bit_3),
        .array_op_start(array_op_start), .array_op_is_erase(array_op_is_erase),
        .array_op_addr(array_op_addr), .read_addr(read_addr),
        .read_allowed(read_allowed), .write_in_progress(write_in_progress),
        .write_enable_latch(write_enable_latch), .suspend_flags(suspend_flags),
        .reset_busy(reset_busy), .continuous_read_mode_bits(),
        .wrap_setting_bits());
    fss_host_model u_fss_host_model (.core_clk(core_clk), .cs_n(cs_n),
        .sclk(sclk), .si(si), .so(so));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    function automatic [23:0] sec_addr(input int k, input [8:0] off);
        return {8'h00, k[3:0], 3'b000, off};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic send(input logic [63:0] tx, input int n);
        u_fss_host_model.frame(tx, n, 0, rx);
    endtask

    task automatic rd(input logic [23:0] a, input int nb);
        u_fss_host_model.frame({`FSS_OP_SEC_READ, a, 8'h00}, 40, nb * 8, rx);
    endtask

    task automatic wait_idle;
        for (int k = 0; k < 6000 && write_in_progress !== 1'b0; k++) tick(1);
        `CHK(write_in_progress, 1'b0)
    endtask

    // Refused writes leave the latch set; later writes clear it
    task automatic try_write(input logic [63:0] tx, input int n,
                             input logic we, input logic go);
        if (we) send(`FSS_OP_WRITE_ENABLE_CMD, 8);
        send(tx, n);
        tick(8);
        `CHK(write_in_progress, go)
        wait_idle();
        if (go) `CHK(write_enable_latch, 1'b0)
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge core_clk);
        mismatches++;
        test_done();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        seed = 32'h73BBE347;
        rst_n = 1'b0;
        {sec_lock_bit_3, sec_lock_bit_2, sec_lock_bit_1} = 3'b100;
        {array_op_start, array_op_is_erase} = 2'b00;
        array_op_addr = 24'h000000;
        read_addr = 24'h000000;
        mismatches = 0;
        cmp_count = 0;
        tick(5);
        rst_n = 1'b1;
        tick(4);
        u_fss_host_model.frame({`FSS_OP_UID, 32'h0}, 40, 128, rx);
        `CHK(rx, UID)
        try_write({`FSS_OP_SEC_ERASE, sec_addr(3, 0)}, 32, 1, 0);
        send(`FSS_OP_WRDI, 8);
        try_write({`FSS_OP_SEC_ERASE, sec_addr(1, 0)}, 32, 0, 0);
        try_write({`FSS_OP_SEC_ERASE, sec_addr(1, 0)} >> 1, 31, 1, 0);
        try_write({`FSS_OP_SEC_ERASE, sec_addr(1, 0), 1'b0}, 33, 1, 0);
        foreach (bad[i])
            try_write({`FSS_OP_SEC_ERASE, bad[i]}, 32, 1, 0);
        for (int k = 1; k < 3; k++)
            try_write({`FSS_OP_SEC_ERASE, sec_addr(k, 0)}, 32, 1, 1);
        b = $random(seed);
        r = $random(seed);
        rd(sec_addr(2, r[8:0]), 1);
        `CHK(rx[7:0], 8'hFF)
        try_write({`FSS_OP_SEC_PROG, sec_addr(1, 9'h1FE), b[15:0]}, 48, 1, 1);
        try_write({`FSS_OP_SEC_PROG, sec_addr(1, 9'h000), b[23:16]}, 40, 1, 1);
        try_write({`FSS_OP_SEC_PROG, sec_addr(1, 9'h005)}, 32, 1, 0);
        try_write({`FSS_OP_SEC_PROG, sec_addr(3, 9'h000), b[7:0]}, 40, 1, 0);
        rd(sec_addr(1, 9'h1FE), 3);
        `CHK(rx[23:0], {b[15:0], b[23:16]})
        send(`FSS_OP_SUSPEND, 8);
        `CHK(suspend_flags, 2'b00)
        send(`FSS_OP_RESUME, 8);
        tick(24);
        `CHK(write_in_progress, 1'b0)
        for (int e = 0; e < 2; e++) begin
            send(`FSS_OP_WRITE_ENABLE_CMD, 8);
            array_op_addr = 24'($random(seed));
            array_op_is_erase = e[0];
            array_op_start = 1'b1;
            tick(1);
            array_op_start = 1'b0;
            tick(8);
            send(`FSS_OP_SUSPEND, 8);
            `CHK(suspend_flags, e ? 2'b10 : 2'b01)
            wait_idle();
            read_addr = array_op_addr;
            tick(1);
            `CHK(read_allowed, 1'b0)
            read_addr = array_op_addr ^ 24'h001000;
            tick(1);
            `CHK(read_allowed, 1'b1)
            try_write({`FSS_OP_SEC_ERASE, sec_addr(1, 0)}, 32, 1, 0);
            if (e == 0)
                try_write({`FSS_OP_SEC_PROG, sec_addr(2, 0), 8'h00}, 40, 1, 0);
            send(`FSS_OP_WRDI, 8);
            send(`FSS_OP_RESUME, 8);
            `CHK(suspend_flags, 2'b00)
            tick(12);
            `CHK(write_in_progress, 1'b1)
            wait_idle();
        end
        `CHK({write_in_progress, suspend_flags}, 3'b000)
        send(`FSS_OP_RST_EN, 8);
        send(`FSS_OP_WRITE_ENABLE_CMD, 8);
        send(`FSS_OP_RST, 8);
        `CHK(reset_busy, 1'b0)
        array_op_is_erase = 1'b1;
        array_op_start = 1'b1;
        tick(1);
        array_op_start = 1'b0;
        send(`FSS_OP_RST_EN, 8);
        send(`FSS_OP_RST, 8);
        `CHK(reset_busy, 1'b1)
        `CHK(write_in_progress, 1'b0)
        `CHK(write_enable_latch, 1'b0)
        send(`FSS_OP_WRITE_ENABLE_CMD, 8);
        `CHK(write_enable_latch, 1'b0)
        for (int k = 0; k < 1000 && reset_busy !== 1'b0; k++) tick(1);
        send(`FSS_OP_WRITE_ENABLE_CMD, 8);
        `CHK(write_enable_latch, 1'b1)
        test_done();
    end
endmodule // fss_ctrl_tb
